// >>> hw/csw_clock_switch.v
// clock switch, fail-safe monitor and sleep/idle controller with wishbone registers
// Operation
// - switching and monitor only when enable cfg zero
// - switching disabled: ignore request, report initial source
// - switching disabled: switch request held zero
// - equal sources: clear request, abort quietly
// - valid switch clears lock and fail flags
// - start target, wait startup timer, PLL lock
// - count ten new-clock cycles before changeover
// - completion clears request, copies requested source
// - stop old source, keep rc/crystal exceptions
// - cpu run held during the switch, clock gated in the swap step
// - primary submode fixed by configuration only
// - monitor keeps low-power rc on except sleep
// - failure raises trap, falls back to fast rc
// - fallback keeps pll when pll was used
// - sleep or idle only via power-save instruction
// - sleep stops clocks, monitor, clears watchdog
// - wake from sleep on interrupt, reset, watchdog
// - idle halts cpu, clock runs, clears watchdog
// - idle wake resumes cpu two to four cycles
// - interrupt during power-save deferred then wakes
// - fail flag set on detection, software clears
// - request bit one requests, zero means done
`timescale 1ns/1ps
`include "csw_map.vh"
module csw_clock_switch #(
  parameter OST_CYC = 16'h0400
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // configuration straps
  input  wire        switch_enable_cfg_i,
  input  wire [2:0]  initial_source_cfg_i,
  input  wire [1:0]  primary_submode_cfg_i,
  // oscillator status pins (asynchronous)
  input  wire        src_tick_i,
  input  wire        pll_lock_i,
  input  wire        osc_alive_i,
  // processor side
  input  wire        power_save_instruction_exec_i,
  input  wire        power_save_instruction_sleep_i,
  input  wire        irq_pending_i,
  input  wire        wdt_enable_i,
  input  wire        wdt_timeout_i,
  // outputs
  output reg  [2:0]  sys_src_o,
  output reg  [5:0]  osc_run_o,
  output reg  [1:0]  primary_submode_o,
  output reg         sys_clk_gate_o,
  output reg         cpu_run_o,
  output reg         wdt_clear_o,
  output reg         clock_fail_trap_o,
  output reg         low_power_rc_on_o
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_START  = 3'h1;
  localparam ST_SETTLE = 3'h2;
  localparam ST_SWAP   = 3'h3;
  localparam PW_RUN    = 2'h0;
  localparam PW_IDLE   = 2'h1;
  localparam PW_SLEEP  = 2'h2;
  localparam PW_WAKE   = 2'h3;
  localparam [3:0] SETTLE_LAST = `CSW_SETTLE_CYC - 4'h1;
  localparam [1:0] WAKE_LAST   = `CSW_WAKE_CYC - 2'h1;

  // synchronisers
  reg  [2:0] sync1_reg;
  reg  [2:0] sync2_reg;
  reg        tick_d_reg;
  wire       tick_s   = sync2_reg[0];
  wire       lock_s   = sync2_reg[1];
  wire       alive_s  = sync2_reg[2];
  wire       tick_rise = tick_s & ~tick_d_reg;

  // straps caught after reset release
  reg        cfg_taken_reg;
  reg        sw_en_reg;
  reg  [2:0] init_src_reg;

  reg  [2:0] req_src_reg;
  reg  [2:0] cur_src_reg;
  reg        swreq_reg;
  reg        lock_flag_reg;
  reg        fail_reg;
  reg        lpx_en_reg;
  reg  [1:0] unlock_reg;
  reg  [2:0] st_reg;
  reg  [15:0] cnt_reg;
  reg  [7:0] fail_cnt_reg;
  reg  [1:0] pw_reg;
  reg  [1:0] wake_cnt_reg;
  reg        defer_reg;

  wire       sw_allowed = cfg_taken_reg & ~sw_en_reg;
  wire       mon_on     = sw_allowed & (pw_reg != PW_SLEEP);
  wire       is_pll     = (cur_src_reg == `CSW_SRC_PRIPLL) |
                          (cur_src_reg == `CSW_SRC_FAST_RC_WITH_PLL);
  wire       tgt_pll    = (req_src_reg == `CSW_SRC_PRIPLL) |
                          (req_src_reg == `CSW_SRC_FAST_RC_WITH_PLL);
  wire       tgt_xtal   = (req_src_reg == `CSW_SRC_PRI) | (req_src_reg == `CSW_SRC_PRIPLL) |
                          (req_src_reg == `CSW_SRC_LPXTAL);

  // a write lands at the edge where ack is seen high, as the master sees it
  wire       wr         = cyc_i & stb_i & we_i & ack_o;
  wire       wr_cfg     = wr && adr_i == `CSW_OFF_CFG && sel_i[0];
  wire       wr_ctrl    = wr && adr_i == `CSW_OFF_CTRL && unlock_reg == 2'h2;
  wire       wake_ev    = irq_pending_i | wdt_timeout_i;

  // fallback only from a source that can die; the fast rc is the refuge
  wire       fail_det   = mon_on && (st_reg == ST_IDLE) &&
                          fail_cnt_reg == `CSW_FAIL_CYC &&
                          cur_src_reg != `CSW_SRC_FRC &&
                          cur_src_reg != `CSW_SRC_FAST_RC_WITH_PLL;
  wire [2:0] shown_cur  = sw_allowed ? cur_src_reg : init_src_reg;
  wire [2:0] ost_hi     = 3'h0;

  // read views; unused bits read as zero
  wire [31:0] ctrl_word = {17'h0,
                           shown_cur,
                           1'b0,
                           req_src_reg,
                           2'h0,
                           lock_flag_reg,
                           1'b0,
                           fail_reg,
                           2'h0,
                           swreq_reg};
  wire [31:0] cfg_word  = {26'h0,
                           primary_submode_o,
                           lpx_en_reg,
                           sw_allowed,
                           unlock_reg};
  wire [31:0] stat_word = {24'h0,
                           osc_run_o,
                           pw_reg};

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg  <= 3'h0;
      sync2_reg  <= 3'h0;
      tick_d_reg <= 1'b0;
    end else begin
      sync1_reg  <= {osc_alive_i, pll_lock_i, src_tick_i};
      sync2_reg  <= sync1_reg;
      tick_d_reg <= tick_s;
    end
  end

  // wishbone: one registered ack per request, one cycle after the strobe, ack drops after one cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= 32'h0;
      if (cyc_i & stb_i & ~ack_o & ~we_i) begin
        case (adr_i)
          `CSW_OFF_CTRL: dat_o <= ctrl_word;
          `CSW_OFF_CFG:  dat_o <= cfg_word;
          `CSW_OFF_STAT: dat_o <= stat_word;
          default:       dat_o <= 32'h0;
        endcase
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_taken_reg     <= 1'b0;
      sw_en_reg         <= 1'b1;
      init_src_reg      <= `CSW_SRC_FRC;
      primary_submode_o <= 2'h0;
      req_src_reg       <= `CSW_SRC_FRC;
      cur_src_reg       <= `CSW_SRC_FRC;
      swreq_reg         <= 1'b0;
      lock_flag_reg     <= 1'b0;
      fail_reg          <= 1'b0;
      lpx_en_reg        <= 1'b0;
      unlock_reg        <= 2'h0;
      st_reg            <= ST_IDLE;
      cnt_reg           <= 16'h0;
      fail_cnt_reg      <= 8'h0;
      clock_fail_trap_o <= 1'b0;
    end else begin
      clock_fail_trap_o <= 1'b0;
      lock_flag_reg     <= lock_s;
      // straps freeze here; later pin changes are ignored
      if (!cfg_taken_reg) begin
        cfg_taken_reg     <= 1'b1;
        sw_en_reg         <= switch_enable_cfg_i;
        init_src_reg      <= initial_source_cfg_i;
        cur_src_reg       <= initial_source_cfg_i;
        req_src_reg       <= initial_source_cfg_i;
        primary_submode_o <= primary_submode_cfg_i;
      end

      // unlock key pair, then one protected write
      if (wr_cfg) begin
        if (dat_i[7:0] == `CSW_KEY1) begin
          unlock_reg <= 2'h1;
        end else if (unlock_reg == 2'h1 && dat_i[7:0] == `CSW_KEY2) begin
          unlock_reg <= 2'h2;
        end else begin
          unlock_reg <= 2'h0;
        end
        if (sel_i[1]) begin
          lpx_en_reg <= dat_i[8];
        end
      end

      if (wr_ctrl) begin
        unlock_reg <= 2'h0;
        if (sel_i[1] && sw_allowed) begin
          req_src_reg <= dat_i[`CSW_REQ_HI:`CSW_REQ_LO];
        end
        if (sel_i[0] && !dat_i[`CSW_BIT_FAIL]) begin
          fail_reg <= 1'b0;
        end
        if (sel_i[0] && dat_i[`CSW_BIT_SWREQ] && sw_allowed && st_reg == ST_IDLE) begin
          swreq_reg <= 1'b1;
        end
      end

      // failure watchdog: counts only while source ticks stop and the alive status is low
      if (!mon_on || tick_rise || st_reg != ST_IDLE || alive_s) begin
        fail_cnt_reg <= 8'h0;
      end else if (fail_cnt_reg != `CSW_FAIL_CYC) begin
        fail_cnt_reg <= fail_cnt_reg + 8'h01;
      end

      // set after the software clear, so a coincident failure wins
      if (fail_det) begin
        fail_reg          <= 1'b1;
        clock_fail_trap_o <= 1'b1;
        cur_src_reg       <= is_pll ? `CSW_SRC_FAST_RC_WITH_PLL : `CSW_SRC_FRC;
        req_src_reg       <= is_pll ? `CSW_SRC_FAST_RC_WITH_PLL : `CSW_SRC_FRC;
        swreq_reg         <= 1'b0;
      end

      // switch sequence; cpu run stays high, system clock gated in ST_SWAP
      case (st_reg)
        ST_IDLE: begin
          if (swreq_reg && !fail_det) begin
            if (req_src_reg == cur_src_reg) begin
              swreq_reg <= 1'b0;
            end else begin
              fail_reg      <= 1'b0;
              lock_flag_reg <= 1'b0;
              cnt_reg       <= 16'h0;
              st_reg        <= ST_START;
            end
          end
        end

        ST_START: begin
          if (tgt_xtal && cnt_reg != OST_CYC)
            cnt_reg <= cnt_reg + 16'h0001;
          else if (!tgt_pll || lock_s) begin
            cnt_reg <= {ost_hi, 13'h0};
            st_reg  <= ST_SETTLE;
          end
        end

        ST_SETTLE: begin
          if (tick_rise) begin
            if (cnt_reg[3:0] == SETTLE_LAST) begin
              st_reg <= ST_SWAP;
            end else begin
              cnt_reg <= cnt_reg + 16'h0001;
            end
          end
        end

        // swap on a source tick so no clock phase is cut short
        ST_SWAP: begin
          if (tick_rise) begin
            cur_src_reg <= req_src_reg;
            swreq_reg   <= 1'b0;
            st_reg      <= ST_IDLE;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // power-save modes
  always @(posedge clk_i) begin
    if (rst_i) begin
      pw_reg       <= PW_RUN;
      wake_cnt_reg <= 2'h0;
      defer_reg    <= 1'b0;
      wdt_clear_o  <= 1'b0;
    end else begin
      wdt_clear_o <= 1'b0;
      case (pw_reg)
        PW_RUN: begin
          if (power_save_instruction_exec_i) begin
            wdt_clear_o <= 1'b1;
            // an interrupt seen with the instruction wakes right after entry
            defer_reg   <= irq_pending_i;
            pw_reg      <= power_save_instruction_sleep_i ? PW_SLEEP : PW_IDLE;
          end
        end

        PW_IDLE, PW_SLEEP: begin
          defer_reg <= 1'b0;
          if (wake_ev || defer_reg) begin
            wake_cnt_reg <= 2'h0;
            pw_reg       <= PW_WAKE;
          end
        end

        PW_WAKE: begin
          if (wake_cnt_reg == WAKE_LAST) begin
            pw_reg <= PW_RUN;
          end else begin
            wake_cnt_reg <= wake_cnt_reg + 2'h1;
          end
        end
        default: pw_reg <= PW_RUN;
      endcase
    end
  end

  // oscillator enables: current and target run, plus the kept low-power rc and crystal; in sleep only the kept ones run
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_osc
      wire used_cur = (cur_src_reg == g) || (cur_src_reg == `CSW_SRC_PRIPLL && g == `CSW_SRC_PRI) ||
                      (cur_src_reg == `CSW_SRC_FAST_RC_WITH_PLL && g == `CSW_SRC_FRC);
      wire used_tgt = (st_reg != ST_IDLE) && ((req_src_reg == g) ||
                      (req_src_reg == `CSW_SRC_PRIPLL && g == `CSW_SRC_PRI) ||
                      (req_src_reg == `CSW_SRC_FAST_RC_WITH_PLL && g == `CSW_SRC_FRC));
      wire keep     = (g == `CSW_SRC_LPXTAL && lpx_en_reg) ||
                      (g == `CSW_SRC_LOW_POWER_RC && ((mon_on && pw_reg != PW_SLEEP) || wdt_enable_i));
      always @(posedge clk_i) begin
        if (rst_i) begin
          osc_run_o[g] <= 1'b0;
        end else if (pw_reg == PW_SLEEP) begin
          osc_run_o[g] <= keep;
        end else begin
          osc_run_o[g] <= used_cur | used_tgt | keep;
        end
      end
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i) begin
      sys_src_o         <= `CSW_SRC_FRC;
      sys_clk_gate_o    <= 1'b0;
      cpu_run_o         <= 1'b0;
      low_power_rc_on_o <= 1'b0;
    end else begin
      sys_src_o         <= shown_cur;
      sys_clk_gate_o    <= cfg_taken_reg && pw_reg != PW_SLEEP &&
                           st_reg != ST_SWAP;
      cpu_run_o         <= cfg_taken_reg && pw_reg == PW_RUN;
      low_power_rc_on_o <= (mon_on && pw_reg != PW_SLEEP) || wdt_enable_i;
    end
  end
endmodule

// >>> hw/csw_map.vh
// register offsets, field positions and timing counts for the clock switch block
`ifndef CSW_MAP_VH
`define CSW_MAP_VH
`define CSW_OFF_CTRL      8'h00
`define CSW_OFF_CFG       8'h04
`define CSW_OFF_PWR       8'h08
`define CSW_OFF_STAT      8'h0C
`define CSW_BIT_SWREQ     0
`define CSW_BIT_FAIL      3
`define CSW_BIT_LOCK      5
`define CSW_REQ_LO        8
`define CSW_REQ_HI        10
`define CSW_CUR_LO        12
`define CSW_CUR_HI        14
`define CSW_SRC_FRC       3'h0
`define CSW_SRC_FAST_RC_WITH_PLL    3'h1
`define CSW_SRC_PRI       3'h2
`define CSW_SRC_PRIPLL    3'h3
`define CSW_SRC_LPXTAL    3'h4
`define CSW_SRC_LOW_POWER_RC      3'h5
`define CSW_SETTLE_CYC    4'hA
`define CSW_OST_CYC       16'h0400
`define CSW_FAIL_CYC      8'h40
`define CSW_WAKE_CYC      2'h2
`define CSW_KEY1          8'h46
`define CSW_KEY2          8'h57
`endif

// >>> sim/csw_clock_switch_test.sv
// self-checking bench for the clock switch block
`timescale 1ns/1ps
`include "csw_map.vh"
module csw_clock_switch_test;
  reg         clk_i = 0;
  reg         rst_i = 1;
  reg         cyc_i = 0;
  reg         stb_i = 0;
  reg         we_i = 0;
  reg  [7:0]  adr_i = 0;
  reg  [3:0]  sel_i = 0;
  reg  [31:0] dat_i = 0;
  reg         dis = 1;
  reg  [2:0]  isrc = 0;
  reg         fail = 0;
  reg         pwr = 0;
  reg         slp = 0;
  reg         irq = 0;
  reg         wto = 0;
  reg         wden = 1;
  reg         seen = 0;
  reg         k;
  reg  [31:0] rd;
  wire [31:0] dat_o;
  wire [5:0]  orun;
  wire [2:0]  src;
  wire [1:0]  sub;
  wire        ack_o, tick, lock, alive, gate, run, wclr, trap, low_power_rc;
  integer     errors = 0, compares = 0, cyc_n = 0, n;
  always #2.5 clk_i = ~clk_i;
  csw_clock_switch #(.OST_CYC(16'h0010)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .switch_enable_cfg_i(dis), .initial_source_cfg_i(isrc),
    .primary_submode_cfg_i(2'h1), .src_tick_i(tick), .pll_lock_i(lock), .osc_alive_i(alive),
    .power_save_instruction_exec_i(pwr), .power_save_instruction_sleep_i(slp), .irq_pending_i(irq), .wdt_enable_i(wden),
    .wdt_timeout_i(wto), .sys_src_o(src), .osc_run_o(orun), .primary_submode_o(sub),
    .sys_clk_gate_o(gate), .cpu_run_o(run), .wdt_clear_o(wclr), .clock_fail_trap_o(trap),
    .low_power_rc_on_o(low_power_rc));
  csw_osc_model osc_u (.clk_i(clk_i), .osc_run_i(orun), .fail_i(fail), .tick_o(tick),
    .lock_o(lock), .alive_o(alive));
  always @(posedge clk_i) begin
    if (wclr === 1'b1)
      seen <= 1'b1;
    cyc_n = cyc_n + 1;
    if (cyc_n == 20000) begin
      errors = errors + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      if (errors == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [8*6:1] nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // hold the request until ack is sampled high, then idle one cycle
  task wb(input w, input [7:0] a, input [3:0] s, input [31:0] d);
    begin
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task ctrl(input [3:0] s, input [31:0] d);
    begin
      wb(1'b1, `CSW_OFF_CFG, 4'h1, {24'h0, `CSW_KEY1});
      wb(1'b1, `CSW_OFF_CFG, 4'h1, {24'h0, `CSW_KEY2});
      wb(1'b1, `CSW_OFF_CTRL, s, d);
    end
  endtask
  task req(input [2:0] s);
    begin
      ctrl(4'h2, {21'h0, s, 8'h00});
      ctrl(4'h1, 32'h1);
      wb(1'b0, `CSW_OFF_CTRL, 4'hF, 32'h0);
    end
  endtask
  task do_reset(input d, input [2:0] s);
    begin
      rst_i <= 1'b1;
      dis <= d;
      isrc <= s;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task t_disabled;
    begin
      do_reset(1'b1, `CSW_SRC_PRI);
      req(`CSW_SRC_LOW_POWER_RC);
      chk("swreq", 0, rd[0]);
      chk("cursrc", 2, rd[14:12]);
      chk("submod", 1, sub);
      wb(1'b0, 8'h10, 4'hF, 32'h0);
      chk("unmap", 0, rd);
    end
  endtask
  task t_switch;
    begin
      do_reset(1'b0, `CSW_SRC_FRC);
      req(`CSW_SRC_FRC);
      chk("redund", 0, rd[0]);
      req(`CSW_SRC_PRIPLL);
      n = 0;
      k = 1'b1;
      while (src !== `CSW_SRC_PRIPLL) begin
        @(posedge clk_i);
        n = n + 1;
        k = k & run;
      end
      chk("settle", 1, n > 18);
      chk("cpurun", 1, k);
      wb(1'b0, `CSW_OFF_CTRL, 4'hF, 32'h0);
      chk("done", 3, {rd[14:12], rd[0]} >> 1);
      chk("swreq", 0, rd[0]);
      chk("fail0", 0, rd[3]);
      chk("runnew", 1, orun[3]);
      chk("oldoff", 0, orun[0]);
    end
  endtask
  task t_fail;
    begin
      fail <= 1'b1;
      wden <= 1'b0;
      while (trap !== 1'b1) @(posedge clk_i);
      fail <= 1'b0;
      repeat (45) @(posedge clk_i);
      chk("fbsrc", 1, src);
      chk("low_power_rc", 1, low_power_rc);
      wb(1'b0, `CSW_OFF_CTRL, 4'hF, 32'h0);
      chk("cflag", 1, rd[3]);
      ctrl(4'h1, 32'h0);
      wb(1'b0, `CSW_OFF_CTRL, 4'hF, 32'h0);
      chk("cclr", 0, rd[3]);
      wden <= 1'b1;
    end
  endtask
  task t_power;
    begin
      seen = 1'b0;
      pwr <= 1'b1;
      @(posedge clk_i);
      pwr <= 1'b0;
      while (run !== 1'b0) @(posedge clk_i);
      chk("idlclk", 1, gate);
      chk("wdclr", 1, seen);
      irq <= 1'b1;
      n = 0;
      while (run !== 1'b1) begin
        @(posedge clk_i);
        n = n + 1;
      end
      chk("wake", 1, n >= 2 && n <= 5);
      irq <= 1'b0;
      slp <= 1'b1;
      pwr <= 1'b1;
      @(posedge clk_i);
      pwr <= 1'b0;
      while (gate !== 1'b0) @(posedge clk_i);
      repeat (5) @(posedge clk_i);
      chk("sleep", 0, {run, orun[4:0]});
      wto <= 1'b1;
      while (run !== 1'b1) @(posedge clk_i);
      wto <= 1'b0;
      chk("slpsrc", 1, src);
      irq <= 1'b1;
      pwr <= 1'b1;
      @(posedge clk_i);
      pwr <= 1'b0;
      irq <= 1'b0;
      repeat (12) @(posedge clk_i);
      chk("defer", 1, run);
    end
  endtask
  initial begin
    t_disabled;
    t_switch;
    t_fail;
    t_power;
    print_verdict;
  end
endmodule

// >>> sim/csw_osc_model.sv
// oscillator sources: tick, pll lock and alive status
`timescale 1ns/1ps
module csw_osc_model #(
  parameter DIV = 2
) (
  input  wire       clk_i,
  input  wire [5:0] osc_run_i,
  input  wire       fail_i,
  output reg        tick_o,
  output reg        lock_o,
  output reg        alive_o
);
  integer n = 0;
  initial tick_o = 1'b0;
  // a dead or unstarted source holds its tick low, so it shows no rising edges
  always @(posedge clk_i) begin
    n <= (n + 1) % DIV;
    if (fail_i || osc_run_i == 6'h00)
      tick_o <= 1'b0;
    else if (n == 0)
      tick_o <= ~tick_o;
    lock_o <= (osc_run_i[1] | osc_run_i[3]) & ~fail_i;
    alive_o <= ~fail_i;
  end
endmodule

// >>> sim/csw_sva.sv
// assertions on bus, switching, fallback and power-save ports
`timescale 1ns/1ps
module csw_sva (
  // clock, reset and bus
  input wire       clk_i,
  input wire       rst_i,
  input wire       cyc_i,
  input wire       stb_i,
  input wire       ack_o,
  // straps and processor side
  input wire       switch_enable_cfg_i,
  input wire [2:0] initial_source_cfg_i,
  input wire       power_save_instruction_exec_i,
  input wire       power_save_instruction_sleep_i,
  input wire       irq_pending_i,
  input wire       wdt_enable_i,
  // outputs
  input wire [2:0] sys_src_o,
  input wire       sys_clk_gate_o,
  input wire       cpu_run_o,
  input wire       wdt_clear_o,
  input wire       clock_fail_trap_o,
  input wire       low_power_rc_on_o
);
  reg [1:0] rel_reg;
  // straps are caught after release, so guard with a short count
  always @(posedge clk_i) begin
    if (rst_i)
      rel_reg <= 2'h0;
    else if (rel_reg != 2'h3)
      rel_reg <= rel_reg + 2'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_sleep;
    power_save_instruction_exec_i && power_save_instruction_sleep_i && cpu_run_o && !irq_pending_i && wdt_enable_i;
  endsequence
  sequence s_idle;
    power_save_instruction_exec_i && !power_save_instruction_sleep_i && cpu_run_o && !irq_pending_i;
  endsequence
  AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus ack not a single pulse");
  AST_DIS_SRC: assert property (rel_reg == 2'h3 && switch_enable_cfg_i |->
    sys_src_o == initial_source_cfg_i) else $error("source moved while switching disabled");
  AST_TRAP_EN: assert property (clock_fail_trap_o |-> !switch_enable_cfg_i)
    else $error("trap while monitor disabled");
  AST_FALLBACK: assert property ($rose(clock_fail_trap_o) |->
    ##[0:40] (sys_src_o == 3'h0 || sys_src_o == 3'h1)) else $error("no fast rc fallback");
  AST_SLEEP: assert property (s_sleep |-> ##[0:3] wdt_clear_o ##[0:4] !sys_clk_gate_o)
    else $error("sleep entry wrong");
  AST_IDLE: assert property (s_idle |-> ##[1:4] (!cpu_run_o && sys_clk_gate_o))
    else $error("idle entry wrong");
  AST_WAKE: assert property (rel_reg == 2'h3 && !cpu_run_o && irq_pending_i |->
    ##[1:8] cpu_run_o) else $error("no wake on interrupt");
  AST_LOW_POWER_RC: assert property (rel_reg == 2'h3 && !switch_enable_cfg_i && sys_clk_gate_o |->
    low_power_rc_on_o) else $error("low-power rc off under monitor");
endmodule
bind csw_clock_switch csw_sva sva_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .switch_enable_cfg_i(switch_enable_cfg_i),
  .initial_source_cfg_i(initial_source_cfg_i), .power_save_instruction_exec_i(power_save_instruction_exec_i),
  .power_save_instruction_sleep_i(power_save_instruction_sleep_i), .irq_pending_i(irq_pending_i), .wdt_enable_i(wdt_enable_i),
  .sys_src_o(sys_src_o), .sys_clk_gate_o(sys_clk_gate_o), .cpu_run_o(cpu_run_o),
  .wdt_clear_o(wdt_clear_o), .clock_fail_trap_o(clock_fail_trap_o),
  .low_power_rc_on_o(low_power_rc_on_o));
